// [verilog/pfcc_pkg.sv]
/*
 pfcc_pkg: constants for the boost power factor correction control loop.
 assumes a 125 MHz reference clock and 12-bit sampled inputs.
*/
package pfcc_pkg;
   localparam int          PFCC_ADC_W       = 12;
   localparam int          PFCC_DATA_W      = 16;
   localparam int          PFCC_CLK_HZ      = 125_000_000;
   localparam int          PFCC_FSW_HZ      = 30_000;
   // longest period rounds down
   localparam int          PFCC_PERIOD_CYC  = PFCC_CLK_HZ / PFCC_FSW_HZ;
   localparam int          PFCC_FRAC_W      = 12;
   localparam int          PFCC_PAR_W       = 16;
   localparam logic [15:0] PFCC_ZERO        = 16'h0000;
   localparam logic [15:0] PFCC_RAMP_RST    = 16'h0000;
   localparam int          PFCC_MEM_DEPTH   = 16;
   localparam int          PFCC_MEM_AW      = 4;
   // shared memory word indices
   localparam logic [3:0]  PFCC_IDX_VREF    = 4'h0;
   localparam logic [3:0]  PFCC_IDX_VRATE   = 4'h1;
   localparam logic [3:0]  PFCC_IDX_VKP     = 4'h2;
   localparam logic [3:0]  PFCC_IDX_VKI     = 4'h3;
   localparam logic [3:0]  PFCC_IDX_VLIM    = 4'h4;
   localparam logic [3:0]  PFCC_IDX_IKP     = 4'h5;
   localparam logic [3:0]  PFCC_IDX_IKI     = 4'h6;
   localparam logic [3:0]  PFCC_IDX_DMAX    = 4'h7;
   localparam logic [3:0]  PFCC_IDX_RUN     = 4'h8;
   localparam logic [3:0]  PFCC_IDX_IMAG    = 4'h9;
   localparam logic [3:0]  PFCC_IDX_IREF    = 4'ha;
   localparam logic [3:0]  PFCC_IDX_DUTY    = 4'hb;
   localparam logic [3:0]  PFCC_IDX_VRAMP   = 4'hc;
   localparam int          PFCC_N_PARAM     = 9;
   typedef enum logic [2:0] {
      PFCC_IDLE, PFCC_RAMP, PFCC_VLOOP, PFCC_IREF, PFCC_FFWD, PFCC_ILOOP, PFCC_DUTY
   } pfcc_seq_t;
endpackage : pfcc_pkg

// [verilog/pfcc_pi.sv]
/*
 pfcc_pi: one proportional-integral stage with clamped output and integrator.
 assumes the caller strobes step_i once per computation with stable operands.
*/
module pfcc_pi
   import pfcc_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic                ref_clk_i,
   input  wire logic                rst_b_i,
   input  wire logic                clk_en_i,
   input  wire logic                clear_i,
   input  wire logic                step_i,
   input  wire logic signed [W-1:0] err_i,
   input  wire logic signed [W-1:0] kp_i,
   input  wire logic signed [W-1:0] ki_i,
   input  wire logic signed [W-1:0] lim_i,
   output logic signed [W-1:0]      out_o
);
   logic signed [W-1:0]   integ_q;
   logic signed [2*W-1:0] pprod;
   logic signed [2*W-1:0] iprod;
   logic signed [W+1:0]   isum;
   logic signed [W+1:0]   osum;
   logic signed [W-1:0]   integ_d;
   logic signed [W-1:0]   out_d;

   function automatic logic signed [W-1:0] clamp(input logic signed [W+1:0] v,
                                                 input logic signed [W-1:0] hi);
      if (v > $signed({{2{hi[W-1]}}, hi})) begin
         clamp = hi;
      end else if (v < $signed({2'b00, {W{1'b0}}})) begin
         clamp = '0;
      end else begin
         clamp = v[W-1:0];
      end
   endfunction : clamp

   always_comb begin
      pprod   = err_i * kp_i;
      iprod   = err_i * ki_i;
      isum    = {{2{integ_q[W-1]}}, integ_q} + {{2{iprod[2*W-1]}}, iprod[PFCC_FRAC_W +: W]};
      integ_d = clamp(isum, lim_i);
      osum    = {{2{integ_d[W-1]}}, integ_d} + {{2{pprod[2*W-1]}}, pprod[PFCC_FRAC_W +: W]};
      out_d   = clamp(osum, lim_i);
   end

   // integrator held inside the limit so it never winds up
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         integ_q <= '0;
         out_o   <= '0;
      end else if (clk_en_i) begin
         if (clear_i) begin
            integ_q <= '0;
            out_o   <= '0;
         end else if (step_i) begin
            integ_q <= integ_d;
            out_o   <= out_d;
         end
      end
   end

   out_in_lim_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      $signed(lim_i) >= 0 && $past(step_i && clk_en_i && !clear_i)
      && lim_i == $past(lim_i) |-> out_o >= 0 && out_o <= lim_i)
      else $error("pi output outside its limit");
endmodule : pfcc_pi

// [verilog/pfcc_top.sv]
/*
 pfcc_top: power factor correction controller for a boost stage.
 assumes 12-bit samples valid whenever sample_valid_i pulses and a host
 that loads the parameter words before writing the run word.
*/
// Contract
// - inputs are 12-bit bus voltage, boost input current, rectified line voltage
// - voltage loop computes current magnitude holding bus voltage at reference
// - bus voltage reference is rate limited after start
// - current reference is magnitude times rectified line voltage sample
// - feed-forward duty tracks the input voltage waveform
// - duty set so input current follows rectified line voltage shape
// - switching signal at 30 kHz
// - 16-bit fixed point steps scheduled by a sequencer
// - host reads and writes shared memory any time without stalling control; host writes land only while clk_en_i is high
// - after start the engine runs on its own, following host updates
module pfcc_top
   import pfcc_pkg::*;
#(
   parameter int PERIOD_CYC = PFCC_PERIOD_CYC
) (
   input  wire logic                   ref_clk_i,
   input  wire logic                   rst_b_i,
   input  wire logic                   clk_en_i,
   input  wire logic                   sample_valid_i,
   input  wire logic [PFCC_ADC_W-1:0]  bus_voltage_sample_i,
   input  wire logic [PFCC_ADC_W-1:0]  input_current_i,
   input  wire logic [PFCC_ADC_W-1:0]  rectified_line_voltage_i,
   input  wire logic                   host_we_i,
   input  wire logic [PFCC_MEM_AW-1:0] host_addr_i,
   input  wire logic [PFCC_DATA_W-1:0] host_wdata_i,
   output logic      [PFCC_DATA_W-1:0] host_rdata_o,
   output logic                        boost_gate_o,
   output logic                        running_o
);
   localparam int PW = $clog2(PERIOD_CYC + 1);
   logic [PFCC_DATA_W-1:0] mem_q [PFCC_N_PARAM];
   logic [PFCC_DATA_W-1:0] bus_voltage_ref_q;
   logic [PFCC_ADC_W-1:0]  vdc_q, iin_q, vac_q;
   logic signed [15:0]     verr, ierr, imag, iloop;
   logic [31:0]            iref_prod;
   logic [15:0]            iref_q, ffwd_q, duty_q;
   logic [16:0]            duty_sum;
   logic [PW-1:0]          pwm_cnt_q;
   logic [PW+15:0]         duty_prod;
   logic [PW-1:0]          on_cyc_q;
   pfcc_seq_t              seq_q;
   logic                   run;

   assign run       = mem_q[PFCC_IDX_RUN][0];
   assign running_o = run;

   // host words live in flip-flops; one write port, reads are combinational
   for (genvar g = 0; g < PFCC_N_PARAM; g++) begin : g_mem
      always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            mem_q[g] <= PFCC_ZERO;
         end else if (clk_en_i && host_we_i && host_addr_i == PFCC_MEM_AW'(g)) begin
            mem_q[g] <= host_wdata_i;
         end
      end
   end

   always_comb begin
      case (host_addr_i)
         PFCC_IDX_IMAG:  host_rdata_o = imag;
         PFCC_IDX_IREF:  host_rdata_o = iref_q;
         PFCC_IDX_DUTY:  host_rdata_o = duty_q;
         PFCC_IDX_VRAMP: host_rdata_o = bus_voltage_ref_q;
         default: begin
            host_rdata_o = (host_addr_i < PFCC_MEM_AW'(PFCC_N_PARAM)) ? mem_q[host_addr_i]
                                                                    : PFCC_ZERO;
         end
      endcase
   end

   // sample capture
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         vdc_q <= '0;
         iin_q <= '0;
         vac_q <= '0;
      end else if (clk_en_i && sample_valid_i && seq_q == PFCC_IDLE) begin
         vdc_q <= bus_voltage_sample_i;
         iin_q <= input_current_i;
         vac_q <= rectified_line_voltage_i;
      end
   end

   // sequencer: one macro step per cycle, restarts on each sample that arrives in idle while running
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         seq_q <= PFCC_IDLE;
      end else if (clk_en_i) begin
         case (seq_q)
            PFCC_IDLE:  seq_q <= (run && sample_valid_i) ? PFCC_RAMP : PFCC_IDLE;
            PFCC_RAMP:  seq_q <= PFCC_VLOOP;
            PFCC_VLOOP: seq_q <= PFCC_IREF;
            PFCC_IREF:  seq_q <= PFCC_FFWD;
            PFCC_FFWD:  seq_q <= PFCC_ILOOP;
            PFCC_ILOOP: seq_q <= PFCC_DUTY;
            PFCC_DUTY:  seq_q <= PFCC_IDLE;
            default:    seq_q <= PFCC_IDLE;
         endcase
      end
   end

   // reference ramps by at most the rate word per sample; trades startup time for peak power
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bus_voltage_ref_q <= PFCC_RAMP_RST;
      end else if (clk_en_i) begin
         if (!run) begin
            bus_voltage_ref_q <= PFCC_RAMP_RST;
         end else if (seq_q == PFCC_RAMP) begin
            // widened sum so a large rate word cannot wrap past the target
            if (17'(bus_voltage_ref_q) + 17'(mem_q[PFCC_IDX_VRATE]) < 17'(mem_q[PFCC_IDX_VREF])
                && bus_voltage_ref_q < mem_q[PFCC_IDX_VREF]) begin
               bus_voltage_ref_q <= bus_voltage_ref_q + mem_q[PFCC_IDX_VRATE];
            end else begin
               bus_voltage_ref_q <= mem_q[PFCC_IDX_VREF];
            end
         end
      end
   end

   assign verr = $signed(bus_voltage_ref_q) - $signed({4'h0, vdc_q});

   pfcc_pi #(.W(PFCC_DATA_W)) u_vloop (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .clk_en_i  (clk_en_i),
      .clear_i   (!run),
      .step_i    (seq_q == PFCC_VLOOP),
      .err_i     (verr),
      .kp_i      (mem_q[PFCC_IDX_VKP]),
      .ki_i      (mem_q[PFCC_IDX_VKI]),
      .lim_i     (mem_q[PFCC_IDX_VLIM]),
      .out_o     (imag)
   );

   assign iref_prod = 32'(imag) * 32'({4'h0, vac_q});
   assign ierr      = $signed(iref_q) - $signed({4'h0, iin_q});

   // feed-forward duty = 1 - vac/vdc, as a 4.12 fraction of the period
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         iref_q <= '0;
         ffwd_q <= '0;
      end else if (clk_en_i) begin
         if (seq_q == PFCC_IREF) begin
            iref_q <= iref_prod[PFCC_FRAC_W +: 16];
         end
         if (seq_q == PFCC_FFWD) begin
            ffwd_q <= (vdc_q > vac_q) ? 16'((32'(vdc_q - vac_q) << PFCC_FRAC_W) / vdc_q)
                                      : 16'h0000;
         end
      end
   end

   pfcc_pi #(.W(PFCC_DATA_W)) u_iloop (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .clk_en_i  (clk_en_i),
      .clear_i   (!run),
      .step_i    (seq_q == PFCC_ILOOP),
      .err_i     (ierr),
      .kp_i      (mem_q[PFCC_IDX_IKP]),
      .ki_i      (mem_q[PFCC_IDX_IKI]),
      .lim_i     (mem_q[PFCC_IDX_DMAX]),
      .out_o     (iloop)
   );

   assign duty_sum = 17'(ffwd_q) + 17'(iloop);

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         duty_q <= '0;
      end else if (clk_en_i) begin
         if (!run) begin
            duty_q <= '0;
         end else if (seq_q == PFCC_DUTY) begin
            duty_q <= (duty_sum > 17'(mem_q[PFCC_IDX_DMAX])) ? mem_q[PFCC_IDX_DMAX]
                                                              : duty_sum[15:0];
         end
      end
   end

   // duty is a 4.12 fraction of the period; latched at period start to avoid glitches
   assign duty_prod = (PW+16)'(duty_q) * (PW+16)'(PERIOD_CYC);

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pwm_cnt_q    <= '0;
         on_cyc_q     <= '0;
         boost_gate_o <= 1'b0;
      end else if (clk_en_i) begin
         if (pwm_cnt_q == PW'(PERIOD_CYC - 1)) begin
            pwm_cnt_q <= '0;
            on_cyc_q  <= duty_prod[PFCC_FRAC_W +: PW];
         end else begin
            pwm_cnt_q <= pwm_cnt_q + 1'b1;
         end
         boost_gate_o <= run && (pwm_cnt_q < on_cyc_q);
      end
   end

   pwm_period_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      clk_en_i && pwm_cnt_q == PW'(PERIOD_CYC - 1) |=> pwm_cnt_q == 0)
      else $error("pwm period did not wrap");
   ramp_bound_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      run && $past(run) |-> bus_voltage_ref_q <= $past(bus_voltage_ref_q)
      + $past(mem_q[PFCC_IDX_VRATE]) || bus_voltage_ref_q == mem_q[PFCC_IDX_VREF])
      else $error("bus reference stepped faster than the rate");
   seq_order_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      clk_en_i && seq_q == PFCC_VLOOP |=> seq_q == PFCC_IREF)
      else $error("sequencer out of order");
   duty_max_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      seq_q == PFCC_DUTY && clk_en_i && run && $stable(mem_q[PFCC_IDX_DMAX])
      |=> duty_q <= $past(mem_q[PFCC_IDX_DMAX]))
      else $error("duty above its maximum");
   gate_stop_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      !run && clk_en_i |=> !boost_gate_o)
      else $error("gate active while stopped");
   iref_prod_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      seq_q == PFCC_IREF && clk_en_i |=> iref_q == $past(iref_prod[PFCC_FRAC_W +: 16]))
      else $error("current reference not the product");
   host_wr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      clk_en_i && host_we_i && host_addr_i == PFCC_IDX_VREF
      |=> mem_q[PFCC_IDX_VREF] == $past(host_wdata_i))
      else $error("host write lost");
   sample_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      seq_q != PFCC_IDLE |=> $stable(vdc_q) && $stable(vac_q))
      else $error("sample changed mid computation");
endmodule : pfcc_top

// [testbench/pfcc_plant.sv]
/*
 pfcc_plant: boost power stage and sampling front end facing the controller.
 assumes the bench sets the bus and line levels; gate_i comes from the controller.
*/
module pfcc_plant (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        gate_i,
   input  wire logic [11:0] vdc_set_i,
   input  wire logic [11:0] vac_set_i,
   output logic             sample_valid_o           = 1'b0,
   output logic [11:0]      bus_voltage_sample_o     = 12'h000,
   output logic [11:0]      input_current_o          = 12'h000,
   output logic [11:0]      rectified_line_voltage_o = 12'h000
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   int cur = 0;
   // inductor current ramps with the gate; samples only hold in the valid cycle
   always @(negedge ref_clk_i) begin
      cnt = (rst_b_i !== 1'b1) ? 0 : (cnt + 1) % 16;
      cur = (gate_i === 1'b1) ? ((cur < 4087) ? cur + 8 : cur) : ((cur > 7) ? cur - 8 : 0);
      sample_valid_o <= (rst_b_i === 1'b1) && (cnt == 15);
      if ((rst_b_i === 1'b1) && (cnt == 15)) begin
         bus_voltage_sample_o     <= vdc_set_i;
         input_current_o          <= cur[11:0];
         rectified_line_voltage_o <= vac_set_i;
      end else begin
         bus_voltage_sample_o     <= ~bus_voltage_sample_o;
         input_current_o          <= ~input_current_o;
         rectified_line_voltage_o <= ~rectified_line_voltage_o;
      end
   end
endmodule : pfcc_plant

// [testbench/testbench.sv]
/*
 testbench: drives the controller host port and checks words and gate against a model.
 assumes pfcc_pkg and pfcc_plant; the switching period is cut to 64 cycles.
*/
module testbench
   import pfcc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PER = 64;
   logic        ref_clk_i    = 1'b0;
   logic        rst_b_i      = 1'b0;
   logic        clk_en_i     = 1'b1;
   logic        host_we_i    = 1'b0;
   logic [3:0]  host_addr_i  = 4'h0;
   logic [15:0] host_wdata_i = 16'h0000;
   logic [11:0] vdc_set      = 12'h080;
   logic [11:0] vac_set      = 12'h020;
   logic [15:0] host_rdata_o;
   logic [15:0] exp_mem [16] = '{default: 16'h0000};
   logic        boost_gate_o, running_o, sv;
   logic [11:0] vdc_s, iin_s, vac_s;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   int          seed = 7;
   int          cycles = 0;

   pfcc_top #(.PERIOD_CYC(PER)) DUT (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .clk_en_i(clk_en_i), .sample_valid_i(sv), .bus_voltage_sample_i(vdc_s),
      .input_current_i(iin_s), .rectified_line_voltage_i(vac_s), .host_we_i(host_we_i),
      .host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
      .boost_gate_o(boost_gate_o), .running_o(running_o));
   pfcc_plant u_plant (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .gate_i(boost_gate_o),
      .vdc_set_i(vdc_set), .vac_set_i(vac_set), .sample_valid_o(sv),
      .bus_voltage_sample_o(vdc_s), .input_current_o(iin_s),
      .rectified_line_voltage_o(vac_s));

   initial forever #4 ref_clk_i = ~ref_clk_i;

   task automatic end_of_test;
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test

   task automatic chk_range(input string what, input logic [15:0] seen, input int lo, hi);
      samples_checked++;
      if ($isunknown(seen) || seen < lo || seen > hi) begin
         n_mismatch++;
         $display("FAIL %s expected %0d..%0d seen %h", what, lo, hi, seen);
      end
   endtask : chk_range

   task automatic chk_word(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk_word

   // strobe stays up between back-to-back writes; a read drops it
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      host_we_i = 1'b1;
      host_addr_i = a;
      host_wdata_i = d;
      if (a <= PFCC_IDX_RUN) exp_mem[a] = d;
      @(negedge ref_clk_i);
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      host_we_i = 1'b0;
      host_addr_i = a;
      @(negedge ref_clk_i);
      d = host_rdata_o;
   endtask : rd

   task automatic rdw(input logic [3:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      chk_word($sformatf("word %0d", a), d, exp);
   endtask : rdw

   task automatic gate_cnt(input int exp);
      int c = 0;
      repeat (PER) begin
         @(negedge ref_clk_i);
         c += (boost_gate_o === 1'b1);
      end
      chk_range("gate high cycles", 16'(c), exp, exp);
   endtask : gate_cnt

   // hang guard: the whole run needs under 2000 cycles
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 6000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   initial begin
      int          k;
      int          w;
      logic [15:0] v;
      repeat (12) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      rst_b_i = 1'b1;
      for (k = 0; k < 16; k++) rdw(k[3:0], 16'h0000);
      for (k = 0; k < 16; k++) if (k != 8) wr(k[3:0], 16'($random(seed)));
      for (k = 0; k < 16; k++) rdw(k[3:0], exp_mem[k]);
      wr(PFCC_IDX_VREF, 16'h0100);
      wr(PFCC_IDX_VRATE, 16'h0040);
      wr(PFCC_IDX_VKP, 16'h1000);
      wr(PFCC_IDX_VKI, 16'h1000);
      wr(PFCC_IDX_VLIM, 16'h0200);
      wr(PFCC_IDX_IKP, 16'h0000);
      wr(PFCC_IDX_IKI, 16'h0000);
      wr(PFCC_IDX_DMAX, 16'h0400);
      wr(PFCC_IDX_RUN, 16'h0001);
      rdw(PFCC_IDX_RUN, 16'h0001);
      for (k = 0; k < 4 && running_o !== 1'b1; k++) @(negedge ref_clk_i);
      chk_word("running", {15'h0000, running_o}, 16'h0001);
      // ramped reference climbs by the rate per computation, then holds
      for (k = 1; k <= 6; k++) begin
         for (w = 0; w < 20 && sv !== 1'b1; w++) @(negedge ref_clk_i);
         repeat (3) @(negedge ref_clk_i);
         rdw(PFCC_IDX_VRAMP, 16'((k * 64 < 256) ? k * 64 : 256));
      end
      repeat (700) @(negedge ref_clk_i);
      rdw(PFCC_IDX_IMAG, 16'h0200);
      rd(PFCC_IDX_IREF, v);
      chk_word("current ref", v, 16'((32'h0200 * 32'(vac_set)) >> PFCC_FRAC_W));
      rdw(PFCC_IDX_DUTY, 16'h0400);
      gate_cnt(16);
      wr(PFCC_IDX_DMAX, 16'h1000);
      repeat (100) @(negedge ref_clk_i);
      rdw(PFCC_IDX_DUTY, 16'h0c00);
      gate_cnt(48);
      // frozen: a host write must not land and nothing may move
      clk_en_i = 1'b0;
      wr(PFCC_IDX_VREF, 16'h0000);
      rdw(PFCC_IDX_VREF, 16'h0100);
      rdw(PFCC_IDX_DUTY, 16'h0c00);
      gate_cnt((boost_gate_o === 1'b1) ? PER : 0);
      clk_en_i = 1'b1;
      wr(PFCC_IDX_RUN, 16'h0000);
      repeat (10) @(negedge ref_clk_i);
      rdw(PFCC_IDX_DUTY, 16'h0000);
      rdw(PFCC_IDX_VRAMP, 16'h0000);
      chk_word("running", {15'h0000, running_o}, 16'h0000);
      gate_cnt(0);
      end_of_test();
   end
endmodule : testbench
